// [verilog/aer_pkg.sv]
// Constants and types for the correctable error status block
package aer_pkg;

  // Register byte offsets
  localparam logic [11:0] AER_OFF_STATUS = 12'h110;
  localparam logic [11:0] AER_OFF_IRQ_STATUS = 12'h120;
  localparam logic [11:0] AER_OFF_IRQ_MASK = 12'h124;

  // Flag bit positions
  localparam int AER_BIT_RCV = 0;
  localparam int AER_BIT_BAD_PKT = 6;
  localparam int AER_BIT_BAD_LINK = 7;
  localparam int AER_BIT_ROLLOVER = 8;
  localparam int AER_BIT_TIMEOUT = 12;
  localparam int AER_BIT_ADVISORY = 13;
  localparam int AER_BIT_INTERNAL = 14;
  localparam int AER_BIT_HDR_OVF = 15;
  localparam int AER_NUM_FLAGS = 8;

  // Implemented bits and reset values
  localparam logic [31:0] AER_STATUS_IMPL = 32'h0000_f1c1;
  localparam logic [31:0] AER_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] AER_IRQ_MASK_RESET = 32'h0000_0000;

  // Bus answers
  localparam logic [1:0] AER_RESP_OKAY = 2'h0;
  localparam logic [1:0] AER_RESP_DECERR = 2'h3;

  localparam int AER_FEP_W = 5;

  // Event pulses, receiver error in bit 0
  typedef struct packed {
    logic header_log_request;
    logic internal_error;
    logic advisory_nonfatal;
    logic replay_timeout;
    logic replay_rollover;
    logic bad_link_packet;
    logic bad_packet;
    logic receiver_error;
  } aer_events_t;

  typedef enum logic [1:0] {
    AER_REG_NONE = 2'h0,
    AER_REG_STATUS = 2'h1,
    AER_REG_IRQ_STATUS = 2'h3,
    AER_REG_IRQ_MASK = 2'h2
  } aer_reg_t;

  typedef enum logic [1:0] {
    AER_WR_COLLECT = 2'h0,
    AER_WR_RESP = 2'h1
  } aer_wr_state_t;

endpackage

// [verilog/aer_correctable_error_status.sv]
// Correctable error status register with AXI4-Lite access and interrupt
// What this block does
// - Receiver error from the physical layer sets status bit 0.
// - Bad transaction layer packet sets status bit 6.
// - Bad data link layer packet sets status bit 7.
// - Replay counter rollover sets status bit 8.
// - Replay timer expiry sets status bit 12.
// - Advisory non-fatal error sets status bit 13.
// - Correctable internal error on this port sets status bit 14.
// - Header-logging error with header log unavailable sets status bit 15.
// - Header log unavailable while first error pointer indexes a set bit.
// - Flags reset to zero, survive link reset, clear by writing one.
// - Flags set regardless of any mask; masking only gates reporting.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module aer_correctable_error_status
  import aer_pkg::*;
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_reset,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Error events from link layers
  input wire aer_events_t events,
  // Uncorrectable error state
  input wire logic [AER_FEP_W-1:0] first_error_pointer,
  input wire logic [31:0] uncorrectable_error_status,
  // Outputs
  output logic [31:0] correctable_error_status,
  output logic header_log_capture,
  output logic irq
);

  function automatic aer_reg_t reg_decode(input logic [11:0] addr);
    case (addr)
      AER_OFF_STATUS: reg_decode = AER_REG_STATUS;
      AER_OFF_IRQ_STATUS: reg_decode = AER_REG_IRQ_STATUS;
      AER_OFF_IRQ_MASK: reg_decode = AER_REG_IRQ_MASK;
      default: reg_decode = AER_REG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  localparam int FLAG_POS [AER_NUM_FLAGS] = '{
    AER_BIT_RCV, AER_BIT_BAD_PKT, AER_BIT_BAD_LINK, AER_BIT_ROLLOVER,
    AER_BIT_TIMEOUT, AER_BIT_ADVISORY, AER_BIT_INTERNAL, AER_BIT_HDR_OVF
  };

  // Bus state
  aer_wr_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  aer_reg_t wr_sel;
  aer_reg_t rd_sel;
  logic rd_fire;

  // Register state
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [31:0] flag_set;
  logic [31:0] status_clear;
  logic [31:0] irq_clear;
  logic [31:0] next_status;
  logic [31:0] next_irq_status;
  logic pointer_valid;
  logic [AER_NUM_FLAGS-1:0] event_vec;

  // Write channel
  assign s_axi_awready = (wr_state == AER_WR_COLLECT) && !aw_held;
  assign s_axi_wready = (wr_state == AER_WR_COLLECT) && !w_held;
  assign wr_fire = (wr_state == AER_WR_COLLECT) && aw_held && w_held;
  assign wr_sel = reg_decode(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      wr_state <= AER_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AER_RESP_OKAY;
    end else begin
      case (wr_state)
        AER_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state <= AER_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == AER_REG_NONE) ? AER_RESP_DECERR : AER_RESP_OKAY;
          end
        end
        AER_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= AER_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= AER_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Read channel, one read at a time
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = reg_decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AER_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AER_RESP_OKAY;
      case (rd_sel)
        AER_REG_STATUS: s_axi_rdata <= correctable_error_status & AER_STATUS_IMPL;
        AER_REG_IRQ_STATUS: s_axi_rdata <= irq_status;
        AER_REG_IRQ_MASK: s_axi_rdata <= irq_mask;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AER_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Header log is busy while the pointed-to uncorrectable bit is still set
  assign pointer_valid = uncorrectable_error_status[first_error_pointer];

  // Event vector; overflow takes the header request only when log is busy
  always_comb begin
    event_vec = events;
    event_vec[AER_NUM_FLAGS-1] = events.header_log_request && pointer_valid;
  end

  // Map events onto flag positions
  generate
    for (genvar i = 0; i < 32; i++) begin : g_bits
      if (i == AER_BIT_RCV) begin : g_rcv
        assign flag_set[i] = event_vec[0];
      end else if (i == AER_BIT_BAD_PKT) begin : g_bad_pkt
        assign flag_set[i] = event_vec[1];
      end else if (i == AER_BIT_BAD_LINK) begin : g_bad_link
        assign flag_set[i] = event_vec[2];
      end else if (i == AER_BIT_ROLLOVER) begin : g_rollover
        assign flag_set[i] = event_vec[3];
      end else if (i == AER_BIT_TIMEOUT) begin : g_timeout
        assign flag_set[i] = event_vec[4];
      end else if (i == AER_BIT_ADVISORY) begin : g_advisory
        assign flag_set[i] = event_vec[5];
      end else if (i == AER_BIT_INTERNAL) begin : g_internal
        assign flag_set[i] = event_vec[6];
      end else if (i == AER_BIT_HDR_OVF) begin : g_hdr_ovf
        assign flag_set[i] = event_vec[7];
      end else begin : g_rsvd
        assign flag_set[i] = 1'b0;
      end
    end
  endgenerate

  // Clear terms: status write-one-to-clear with byte lanes honoured, interrupt status clear on read
  always_comb begin
    status_clear = 32'h0000_0000;
    if (wr_fire && wr_sel == AER_REG_STATUS) begin
      status_clear = w_data & strobe_mask(w_strb) & AER_STATUS_IMPL;
    end
  end

  always_comb begin
    irq_clear = 32'h0000_0000;
    if (rd_fire && rd_sel == AER_REG_IRQ_STATUS) begin
      irq_clear = 32'hffff_ffff;
    end
  end

  // Set wins over a clear in the same cycle
  assign next_status = (correctable_error_status & ~status_clear) | flag_set;
  assign next_irq_status = (irq_status & ~irq_clear) | flag_set;

  // Sticky flags: only the power-on reset clears them, not link reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      correctable_error_status <= AER_STATUS_RESET;
    end else begin
      correctable_error_status <= next_status & AER_STATUS_IMPL;
    end
  end

  // Interrupt status, cleared by reading it
  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      irq_status <= 32'h0000_0000;
    end else begin
      irq_status <= next_irq_status & AER_STATUS_IMPL;
    end
  end

  // Interrupt mask, gates reporting only
  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      irq_mask <= AER_IRQ_MASK_RESET;
    end else if (wr_fire && wr_sel == AER_REG_IRQ_MASK) begin
      irq_mask <= ((irq_mask & ~strobe_mask(w_strb)) | (w_data & strobe_mask(w_strb)))
                  & AER_STATUS_IMPL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask & AER_STATUS_IMPL);
    end
  end

  // Header captured only when the log is free
  always_ff @(posedge aclk) begin
    if (!aresetn || link_reset) begin
      header_log_capture <= 1'b0;
    end else begin
      header_log_capture <= events.header_log_request && !pointer_valid;
    end
  end

endmodule

// [dv/aer_ces_properties.sv]
// Port checker for the correctable error status block
`timescale 1ns/1ps
module aer_ces_properties
  import aer_pkg::*;
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_reset,
  // Observed signals
  input wire logic s_axi_bvalid,
  input wire aer_events_t events,
  input wire logic [AER_FEP_W-1:0] first_error_pointer,
  input wire logic [31:0] uncorrectable_error_status,
  input wire logic [31:0] correctable_error_status,
  input wire logic header_log_capture
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] st;
  logic busy, hreq;
  assign st = correctable_error_status;
  assign busy = uncorrectable_error_status[first_error_pointer];
  assign hreq = events.header_log_request;
  a_rcv_flag_set: assert property (events.receiver_error |=> st[0])
    else $error("receiver flag not set");
  a_pkt_flag_set: assert property (events.bad_packet |=> st[6])
    else $error("bad packet flag not set");
  a_link_flag_set: assert property (events.bad_link_packet |=> st[7])
    else $error("bad link packet flag not set");
  a_roll_flag_set: assert property (events.replay_rollover |=> st[8])
    else $error("rollover flag not set");
  a_tmo_flag_set: assert property (events.replay_timeout |=> st[12])
    else $error("timeout flag not set");
  a_adv_flag_set: assert property (events.advisory_nonfatal |=> st[13])
    else $error("advisory flag not set");
  a_int_flag_set: assert property (events.internal_error |=> st[14])
    else $error("internal flag not set");
  a_ovf_flag_set: assert property (hreq && busy |=> st[15])
    else $error("overflow flag not set");
  a_busy_no_capture: assert property (hreq && busy |=> !header_log_capture)
    else $error("capture while log busy");
  a_free_log_capture: assert property (hreq && !busy && !link_reset |=> header_log_capture)
    else $error("no capture while log free");
  a_reserved_zero: assert property ((st & ~AER_STATUS_IMPL) == 32'h0)
    else $error("reserved status bit set");
  a_clear_by_write: assert property (|($past(st) & ~st) |-> $rose(s_axi_bvalid))
    else $error("flag cleared without write");
  cover property (hreq && busy);
  cover property ($fell(st[0]));
  cover property (link_reset && st != 32'h0);
endmodule

bind aer_correctable_error_status aer_ces_properties u_props (.aclk, .aresetn, .link_reset,
  .s_axi_bvalid, .events, .first_error_pointer, .uncorrectable_error_status,
  .correctable_error_status, .header_log_capture);

// [dv/aer_correctable_error_status_tb.sv]
// Testbench for the correctable error status block
`timescale 1ns/1ps
module aer_correctable_error_status_tb
  import aer_pkg::*;
;
  logic aclk = 0, aresetn = 0, link_reset = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [31:0] s_axi_wdata = '0, uncorrectable_error_status = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [AER_FEP_W-1:0] first_error_pointer = '0;
  aer_events_t events = '0;
  logic s_axi_rvalid, header_log_capture, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, correctable_error_status;
  int fails = 0, n_tests = 0;

  aer_correctable_error_status u_dut (.aclk, .aresetn, .link_reset,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .events, .first_error_pointer, .uncorrectable_error_status,
    .correctable_error_status, .header_log_capture, .irq);

  initial forever #25 aclk = ~aclk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for one edge
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask

  // One-cycle event pulse, capture judged in the following cycle
  task automatic pulse(input logic [7:0] e, input logic ecap);
    events <= aer_events_t'(e);
    @(posedge aclk);
    events <= '0;
    #1 chk(32'(header_log_capture), 32'(ecap));
    @(posedge aclk);
  endtask

  task automatic s_reset();
    rd(AER_OFF_STATUS, AER_STATUS_RESET, AER_RESP_OKAY);
    rd(AER_OFF_IRQ_MASK, AER_IRQ_MASK_RESET, AER_RESP_OKAY);
    rd(12'h200, 32'h0, AER_RESP_DECERR);
    wr(12'h200, 32'hffff_ffff, AER_RESP_DECERR);
  endtask

  task automatic s_events();
    int pos[8] = '{0, 6, 7, 8, 12, 13, 14, 15};
    uncorrectable_error_status <= 32'h8;
    first_error_pointer <= 5'h3;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h1 << i, 1'b0);
      rd(AER_OFF_STATUS, 32'h1 << pos[i], AER_RESP_OKAY);
      wr(AER_OFF_STATUS, 32'h1 << pos[i], AER_RESP_OKAY);
      rd(AER_OFF_STATUS, 32'h0, AER_RESP_OKAY);
    end
  endtask

  task automatic s_w1c();
    pulse(8'h7f, 1'b0);
    wr(AER_OFF_STATUS, 32'h0, AER_RESP_OKAY);
    rd(AER_OFF_STATUS, 32'h71c1, AER_RESP_OKAY);
    wr(AER_OFF_STATUS, 32'hffff_0e3f, AER_RESP_OKAY);
    rd(AER_OFF_STATUS, 32'h71c0, AER_RESP_OKAY);
    // Low byte lane off: bits 6 and 7 must survive
    s_axi_wstrb <= 4'he;
    wr(AER_OFF_STATUS, 32'hffff_ffff, AER_RESP_OKAY);
    rd(AER_OFF_STATUS, 32'h00c0, AER_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    wr(AER_OFF_STATUS, 32'hffff_ffff, AER_RESP_OKAY);
    rd(AER_OFF_STATUS, 32'h0, AER_RESP_OKAY);
  endtask

  task automatic s_sticky();
    pulse(8'h1, 1'b0);
    link_reset <= 1'b1;
    repeat (3) @(posedge aclk);
    link_reset <= 1'b0;
    @(posedge aclk);
    rd(AER_OFF_STATUS, 32'h1, AER_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(AER_OFF_STATUS, 32'h0, AER_RESP_OKAY);
  endtask

  task automatic s_irq();
    pulse(8'h40, 1'b0);
    #1 chk(32'(irq), 32'h0);
    rd(AER_OFF_STATUS, 32'h4000, AER_RESP_OKAY);
    wr(AER_OFF_IRQ_MASK, 32'h1, AER_RESP_OKAY);
    pulse(8'h1, 1'b0);
    @(posedge aclk);
    #1 chk(32'(irq), 32'h1);
    rd(AER_OFF_IRQ_STATUS, 32'h4001, AER_RESP_OKAY);
    #1 chk(32'(irq), 32'h0);
    wr(AER_OFF_STATUS, 32'h4001, AER_RESP_OKAY);
  endtask

  task automatic s_hdr();
    uncorrectable_error_status <= 32'h0;
    pulse(8'h80, 1'b1);
    rd(AER_OFF_STATUS, 32'h0, AER_RESP_OKAY);
    uncorrectable_error_status <= 32'h8;
    pulse(8'h80, 1'b0);
    rd(AER_OFF_STATUS, 32'h8000, AER_RESP_OKAY);
    first_error_pointer <= 5'h4;
    pulse(8'h80, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_events();
    s_w1c();
    s_sticky();
    s_irq();
    s_hdr();
    end_sim();
  end
endmodule
